// ==== rtl/dacr_top.sv ====
// dacr_top: configuration core of a dual 8-bit converter, serial port on its own clock
// assumes: channel codes arrive on mclk; power select pin is asynchronous
// Summary of operation
// - power register holds two nibble sets; select pin picks low or high nibble
// - default contents: pin high shuts everything down, pin low runs both channels
// - no standby, no channel bits: all off; one channel bit without the averaging bit runs that channel only
// - standby bit set: channels with clear bit go to standby, not full power-down
// - averaging bit with any channel bit runs both and outputs their average
// - while averaging, power-down or standby only when both channel bits clear
// - packed bus select also picks which bus carries averaged data
// - format bit 1: zero gives dual buses, one gives single multiplexed bus
// - format bit 2 picks bus A (A first) or bus B (B first)
// - format bits 3 and 4 reverse pin order of channel A and B buses
// - bits 3:2 set outputs during power-down: 00/10 released, 01 low, 11 high
// - idle bit 1 releases overrange driver, bit 0 releases output clock driver
// - timing bit 7 set bypasses the data aligner; clear uses nominal path
// - timing bit 6 delays data and clock half a period, not in mux mode
// - clock skew field bits 5:3 in sixteenth steps, code 100 reserved
// - data skew field bits 2:0 in sixteenth steps, code 100 reserved
// - clock termination field 000..011 give 50 to 150 ohm, 1xx gives 300
// - data termination field uses the same coding, default 50 ohm
// - transfer is rw bit, seven address bits, eight data bits, MSB first
// - writing 5Ah to the reset address restores all register defaults
`timescale 1ns/1ps
`include "dacr_defs.svh"
module dacr_top
	import dacr_pkg::*;
(
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic sclk,
	input wire logic spi_cs_n,
	input wire logic spi_sdin_i,
	output logic spi_sdin_o,
	output logic spi_sdin_oe,
	input wire logic power_set_select_pin,
	input wire logic [7:0] chan_a_code,
	input wire logic [7:0] chan_b_code,
	input wire logic chan_a_over,
	input wire logic chan_b_over,
	output dacr_chpwr_e first_channel_power,
	output dacr_chpwr_e second_channel_power,
	output logic averaging_active,
	output logic [7:0] bus_a,
	output logic bus_a_oe,
	output logic [7:0] bus_b,
	output logic bus_b_oe,
	output logic overrange_flag_out,
	output logic overrange_oe,
	output logic output_data_clock,
	output logic out_clock_oe,
	output logic aligner_skip,
	output logic half_period_delay,
	output dacr_step_t out_clock_skew_field,
	output dacr_step_t data_skew_field,
	output dacr_term_e first_clock_termination,
	output dacr_term_e first_data_termination,
	output dacr_term_e second_clock_termination,
	output dacr_term_e second_data_termination
);
	dacr_cfg_s cfg_img;
	logic cfg_tgl;
	logic sel_s1_q, sel_s2_q;
	logic tg_s1_q, tg_s2_q, tg_s3_q;
	logic upd;
	dacr_cfg_s cfg_q, cfg_d;
	logic [3:0] act;
	dacr_pwr_s pwr_q, pwr_d;
	logic phase_q, phase_d;
	logic [7:0] ba_q, ba_d, bb_q, bb_d;
	logic ba_oe_q, ba_oe_d, bb_oe_q, bb_oe_d;
	logic ovr_q, ovr_d, ovr_oe_q, ovr_oe_d;
	logic output_data_clock_q, output_data_clock_d, clk_oe_q, clk_oe_d;
	logic algn_q, algn_d, half_q, half_d;
	dacr_step_t cskw_q, cskw_d, dskw_q, dskw_d;
	dacr_term_e tca_q, tca_d, tda_q, tda_d, tcb_q, tcb_d, tdb_q, tdb_d;
	logic a_run, b_run, any_run, idle_oe;
	logic [7:0] avg_val, mux_word, idle_dat;

	dacr_serial u_serial (
		.sclk(sclk),
		.sys_rst(sys_rst),
		.spi_cs_n(spi_cs_n),
		.spi_sdin_i(spi_sdin_i),
		.spi_sdin_o(spi_sdin_o),
		.spi_sdin_oe(spi_sdin_oe),
		.cfg_img(cfg_img),
		.cfg_tgl(cfg_tgl)
	);

	function automatic dacr_pwr_s decode_pwr(input logic [3:0] s);
		dacr_pwr_s p;
		p.avg = 1'b0;
		p.a = s[0] ? CH_RUN : (s[2] ? CH_STBY : CH_OFF);
		p.b = s[1] ? CH_RUN : (s[2] ? CH_STBY : CH_OFF);
		if (s[3] && (s[1] || s[0]))
		begin
			p.avg = 1'b1;
			p.a = CH_RUN;
			p.b = CH_RUN;
		end
		return p;
	endfunction

	// code 100 falls to zero by the same arithmetic as the negative steps
	function automatic dacr_step_t decode_step(input logic [2:0] c);
		return c[2] ? 3'(3'd0 - {1'b0, c[1:0]}) : {1'b0, c[1:0]};
	endfunction

	function automatic dacr_term_e decode_term(input logic [2:0] c);
		if (c[2])
			return TERM_300;
		case (c[1:0])
			2'b00: return TERM_50;
			2'b01: return TERM_75;
			2'b10: return TERM_100;
			default: return TERM_150;
		endcase
	endfunction

	function automatic logic [7:0] reverse8(input logic [7:0] v);
		logic [7:0] r;
		r = 8'h00;
		for (int i = 0; i < 8; i++)
			r[i] = v[7 - i];
		return r;
	endfunction

	// crossings: pin level through two flops, register image by toggle
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			sel_s1_q <= 1'b0;
			sel_s2_q <= 1'b0;
			tg_s1_q <= 1'b0;
			tg_s2_q <= 1'b0;
			tg_s3_q <= 1'b0;
		end
		else
		begin
			sel_s1_q <= power_set_select_pin;
			sel_s2_q <= sel_s1_q;
			tg_s1_q <= cfg_tgl;
			tg_s2_q <= tg_s1_q;
			tg_s3_q <= tg_s2_q;
		end
	end

	assign upd = tg_s2_q ^ tg_s3_q;

	always_comb
	begin
		cfg_d = upd ? cfg_img : cfg_q;
		act = sel_s2_q ? cfg_q.pwr[7:4] : cfg_q.pwr[3:0];
		pwr_d = decode_pwr(act);
		algn_d = cfg_q.skew[`DACR_SKEW_ALIGN];
		half_d = cfg_q.skew[`DACR_SKEW_HALF] && !cfg_q.fmt[`DACR_FMT_SINGLE];
		cskw_d = decode_step(cfg_q.skew[5:3]);
		dskw_d = decode_step(cfg_q.skew[2:0]);
		tca_d = decode_term(cfg_q.term_a[5:3]);
		tcb_d = decode_term(cfg_q.term_b[5:3]);
		tda_d = decode_term(cfg_q.term_a[2:0]);
		tdb_d = decode_term(cfg_q.term_b[2:0]);
	end

	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			cfg_q <= {`DACR_RST_TRMB, `DACR_RST_TRMA, `DACR_RST_SKEW,
				`DACR_RST_IDLE, `DACR_RST_FMT, `DACR_RST_PWR};
			pwr_q <= {1'b0, CH_OFF, CH_OFF};
			algn_q <= 1'b1;
			half_q <= 1'b0;
			cskw_q <= 3'sh0;
			dskw_q <= 3'sh0;
			tca_q <= TERM_50;
			tcb_q <= TERM_50;
			tda_q <= TERM_50;
			tdb_q <= TERM_50;
		end
		else
		begin
			cfg_q <= cfg_d;
			pwr_q <= pwr_d;
			algn_q <= algn_d;
			half_q <= half_d;
			cskw_q <= cskw_d;
			dskw_q <= dskw_d;
			tca_q <= tca_d;
			tcb_q <= tcb_d;
			tda_q <= tda_d;
			tdb_q <= tdb_d;
		end
	end

	// output buses follow the registered power state
	always_comb
	begin
		a_run = pwr_q.a == CH_RUN;
		b_run = pwr_q.b == CH_RUN;
		any_run = a_run || b_run;
		idle_oe = cfg_q.idle[`DACR_IDLE_LO];
		idle_dat = {8{cfg_q.idle[`DACR_IDLE_HI]}};
		avg_val = 8'((9'(chan_a_code) + 9'(chan_b_code)) >> 1);
		mux_word = 8'h00;
		phase_d = ~phase_q;
		ba_d = idle_dat;
		bb_d = idle_dat;
		ba_oe_d = idle_oe;
		bb_oe_d = idle_oe;
		if (pwr_q.avg)
		begin
			if (cfg_q.fmt[`DACR_FMT_PACKSEL])
			begin
				bb_d = avg_val;
				bb_oe_d = 1'b1;
			end
			else
			begin
				ba_d = avg_val;
				ba_oe_d = 1'b1;
			end
		end
		else if (cfg_q.fmt[`DACR_FMT_SINGLE] && any_run)
		begin
			if (cfg_q.fmt[`DACR_FMT_PACKSEL])
			begin
				mux_word = phase_q ? chan_a_code : chan_b_code;
				bb_d = mux_word;
				bb_oe_d = 1'b1;
			end
			else
			begin
				mux_word = phase_q ? chan_b_code : chan_a_code;
				ba_d = mux_word;
				ba_oe_d = 1'b1;
			end
		end
		else if (!cfg_q.fmt[`DACR_FMT_SINGLE])
		begin
			if (a_run)
			begin
				ba_d = chan_a_code;
				ba_oe_d = 1'b1;
			end
			if (b_run)
			begin
				bb_d = chan_b_code;
				bb_oe_d = 1'b1;
			end
		end
		if (cfg_q.fmt[`DACR_FMT_REV_A])
			ba_d = reverse8(ba_d);
		if (cfg_q.fmt[`DACR_FMT_REV_B])
			bb_d = reverse8(bb_d);
		ovr_d = any_run ? ((a_run && chan_a_over) || (b_run && chan_b_over))
			: cfg_q.idle[`DACR_IDLE_HI];
		ovr_oe_d = !cfg_q.idle[`DACR_IDLE_OVR_OFF] && (any_run || idle_oe);
		output_data_clock_d = any_run ? phase_d : cfg_q.idle[`DACR_IDLE_HI];
		clk_oe_d = !cfg_q.idle[`DACR_IDLE_CLK_OFF] && (any_run || idle_oe);
	end

	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			phase_q <= 1'b0;
			ba_q <= 8'h00;
			bb_q <= 8'h00;
			ba_oe_q <= 1'b0;
			bb_oe_q <= 1'b0;
			ovr_q <= 1'b0;
			ovr_oe_q <= 1'b0;
			output_data_clock_q <= 1'b0;
			clk_oe_q <= 1'b0;
		end
		else
		begin
			phase_q <= phase_d;
			ba_q <= ba_d;
			bb_q <= bb_d;
			ba_oe_q <= ba_oe_d;
			bb_oe_q <= bb_oe_d;
			ovr_q <= ovr_d;
			ovr_oe_q <= ovr_oe_d;
			output_data_clock_q <= output_data_clock_d;
			clk_oe_q <= clk_oe_d;
		end
	end

	assign first_channel_power = pwr_q.a;
	assign second_channel_power = pwr_q.b;
	assign averaging_active = pwr_q.avg;
	assign bus_a = ba_q;
	assign bus_b = bb_q;
	assign bus_a_oe = ba_oe_q;
	assign bus_b_oe = bb_oe_q;
	assign overrange_flag_out = ovr_q;
	assign overrange_oe = ovr_oe_q;
	assign output_data_clock = output_data_clock_q;
	assign out_clock_oe = clk_oe_q;
	assign aligner_skip = algn_q;
	assign half_period_delay = half_q;
	assign out_clock_skew_field = cskw_q;
	assign data_skew_field = dskw_q;
	assign first_clock_termination = tca_q;
	assign first_data_termination = tda_q;
	assign second_clock_termination = tcb_q;
	assign second_data_termination = tdb_q;

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (sys_rst);

	sequence s_mux_a_first;
		a_run && b_run && !pwr_q.avg && cfg_q.fmt[4:1] == 4'b0001 && !phase_q;
	endsequence

	sequence s_dual_rev_a;
		a_run && !pwr_q.avg && cfg_q.fmt[`DACR_FMT_REV_A] && !cfg_q.fmt[`DACR_FMT_SINGLE];
	endsequence

	chk_set_select_low: assert property (
		(!sel_s2_q && cfg_q.pwr[0] && !upd) |=> first_channel_power == CH_RUN)
		else $error("low set channel A bit did not run channel A");
	chk_default_shutdown: assert property (
		(sel_s2_q && cfg_q.pwr == `DACR_RST_PWR) |=> first_channel_power == CH_OFF
		&& second_channel_power == CH_OFF)
		else $error("default high set did not shut down");
	chk_full_power_down: assert property (
		(act[2:0] == 3'b000) |=> !averaging_active && first_channel_power == CH_OFF
		&& second_channel_power == CH_OFF)
		else $error("cleared set did not power down");
	chk_standby_entry: assert property (
		(act[2] && !act[0] && !act[3]) |=> first_channel_power == CH_STBY)
		else $error("standby set did not place channel A in standby");
	chk_avg_both_run: assert property (
		(act[3] && act[1:0] != 2'b00) |=> averaging_active
		&& first_channel_power == CH_RUN && second_channel_power == CH_RUN)
		else $error("averaging did not run both channels");
	chk_avg_power_down: assert property (
		(act[3] && act[1:0] == 2'b00) |=> !averaging_active
		&& first_channel_power != CH_RUN)
		else $error("averaging set with no channel bits stayed running");
	chk_avg_bus_a: assert property (
		(pwr_q.avg && cfg_q.fmt[4:2] == 3'b000) |=> bus_a_oe
		&& bus_a == $past(avg_val))
		else $error("average not presented on bus A");
	chk_mux_first_word: assert property (
		s_mux_a_first |=> bus_a_oe && bus_a == $past(chan_a_code))
		else $error("multiplexed bus A did not lead with channel A");
	chk_reverse_order: assert property (
		s_dual_rev_a |=> bus_a == reverse8($past(chan_a_code)))
		else $error("channel A bus not reversed");
	chk_idle_drive_low: assert property (
		(!a_run && !b_run && cfg_q.idle[3:2] == 2'b01) |=> bus_a_oe && bus_a == 8'h00)
		else $error("idle bus not driven low");
	chk_ovr_release: assert property (
		cfg_q.idle[`DACR_IDLE_OVR_OFF] |=> !overrange_oe)
		else $error("overrange driver not released");
	chk_half_mux_off: assert property (
		cfg_q.fmt[`DACR_FMT_SINGLE] |=> !half_period_delay)
		else $error("half period delay active in mux mode");
	chk_skew_reserved: assert property (
		(cfg_q.skew[5:3] == 3'b100) |=> out_clock_skew_field == 3'sh0)
		else $error("reserved clock skew code not nominal");
	chk_cfg_hold: assert property (
		!upd |=> $stable(cfg_q))
		else $error("configuration changed without an update event");
endmodule

// ==== rtl/dacr_defs.svh ====
// dacr_defs.svh: offsets, field positions and reset values of the converter configuration bank
// assumes: included by its bare name from the design modules
`ifndef DACR_DEFS_SVH
`define DACR_DEFS_SVH
`define DACR_ADDR_PWR 7'h00
`define DACR_ADDR_FMT 7'h01
`define DACR_ADDR_IDLE 7'h02
`define DACR_ADDR_SKEW 7'h03
`define DACR_ADDR_TRMA 7'h04
`define DACR_ADDR_TRMB 7'h05
`define DACR_ADDR_DIVF 7'h06
`define DACR_ADDR_RSVD 7'h07
`define DACR_ADDR_CMOD 7'h08
`define DACR_ADDR_SRST 7'h0A
`define DACR_NREGS 9
`define DACR_RST_PWR 8'h03
`define DACR_RST_FMT 8'h00
`define DACR_RST_IDLE 8'h00
`define DACR_RST_SKEW 8'h80
`define DACR_RST_TRMA 8'h00
`define DACR_RST_TRMB 8'h00
`define DACR_RST_OTHER 8'h00
`define DACR_SRST_CODE 8'h5A
`define DACR_STATUS 8'h14
`define DACR_FMT_SINGLE 1
`define DACR_FMT_PACKSEL 2
`define DACR_FMT_REV_A 3
`define DACR_FMT_REV_B 4
`define DACR_IDLE_LO 2
`define DACR_IDLE_HI 3
`define DACR_IDLE_OVR_OFF 1
`define DACR_IDLE_CLK_OFF 0
`define DACR_SKEW_ALIGN 7
`define DACR_SKEW_HALF 6
`endif

// ==== rtl/dacr_pkg.sv ====
// dacr_pkg: types shared by the serial port and the configuration core
// assumes: nothing beyond the defs header
package dacr_pkg;
	typedef enum logic [1:0] {CH_OFF = 2'b00, CH_STBY = 2'b01, CH_RUN = 2'b11} dacr_chpwr_e;
	typedef enum logic [2:0] {
		TERM_50 = 3'b000,
		TERM_75 = 3'b001,
		TERM_100 = 3'b011,
		TERM_150 = 3'b010,
		TERM_300 = 3'b110
	} dacr_term_e;
	typedef struct packed {
		logic [7:0] term_b;
		logic [7:0] term_a;
		logic [7:0] skew;
		logic [7:0] idle;
		logic [7:0] fmt;
		logic [7:0] pwr;
	} dacr_cfg_s;
	typedef struct packed {
		logic avg;
		dacr_chpwr_e a;
		dacr_chpwr_e b;
	} dacr_pwr_s;
	typedef logic signed [2:0] dacr_step_t;
endpackage

// ==== rtl/dacr_serial.sv ====
// dacr_serial: 3-wire serial slave on the link clock, holding the register array
// assumes: host drives cs_n and sdin in step with sclk; sclk may stop between frames
`timescale 1ns/1ps
`include "dacr_defs.svh"
module dacr_serial
	import dacr_pkg::*;
(
	input wire logic sclk,
	input wire logic sys_rst,
	input wire logic spi_cs_n,
	input wire logic spi_sdin_i,
	output logic spi_sdin_o,
	output logic spi_sdin_oe,
	output dacr_cfg_s cfg_img,
	output logic cfg_tgl
);
	logic [7:0] regs_q [0:`DACR_NREGS-1];
	logic [7:0] regs_d [0:`DACR_NREGS-1];
	logic [14:0] sh_q, sh_d;
	logic [4:0] cnt_q, cnt_d;
	logic rd_q, rd_d;
	logic tgl_q, tgl_d;
	logic [7:0] rsh_q, rsh_d;
	logic oe_q, oe_d;
	logic [15:0] word;
	logic [7:0] rdata;
	logic frm_rst;
	logic commit;

	function automatic logic [7:0] rst_val(input int idx);
		case (idx)
			0: rst_val = `DACR_RST_PWR;
			3: rst_val = `DACR_RST_SKEW;
			default: rst_val = `DACR_RST_OTHER;
		endcase
	endfunction

	// frame state clears whenever chip select is high
	assign frm_rst = sys_rst | spi_cs_n;
	assign word = {sh_q, spi_sdin_i};
	assign commit = (cnt_q == 5'd15) && !word[15];

	always_comb
	begin
		sh_d = word[14:0];
		cnt_d = (cnt_q == 5'd16) ? cnt_q : cnt_q + 5'd1;
		rd_d = (cnt_q == 5'd0) ? spi_sdin_i : rd_q;
		regs_d = regs_q;
		tgl_d = tgl_q;
		if (commit)
		begin
			if (word[14:8] == `DACR_ADDR_SRST)
			begin
				if (word[7:0] == `DACR_SRST_CODE)
				begin
					for (int i = 0; i < `DACR_NREGS; i++)
						regs_d[i] = rst_val(i);
					tgl_d = ~tgl_q;
				end
			end
			else if (word[14:8] <= `DACR_ADDR_CMOD && word[14:8] != `DACR_ADDR_RSVD)
			begin
				regs_d[word[11:8]] = word[7:0];
				tgl_d = ~tgl_q;
			end
		end
	end

	always_ff @(posedge sclk or posedge frm_rst)
	begin
		if (frm_rst)
		begin
			sh_q <= 15'h0000;
			cnt_q <= 5'h00;
			rd_q <= 1'b0;
		end
		else
		begin
			sh_q <= sh_d;
			cnt_q <= cnt_d;
			rd_q <= rd_d;
		end
	end

	always_ff @(posedge sclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			for (int i = 0; i < `DACR_NREGS; i++)
				regs_q[i] <= rst_val(i);
			tgl_q <= 1'b0;
		end
		else
		begin
			regs_q <= regs_d;
			tgl_q <= tgl_d;
		end
	end

	// read byte: address sits in sh_q[6:0] after the eighth bit
	always_comb
	begin
		if (sh_q[6:0] == `DACR_ADDR_SRST)
			rdata = `DACR_STATUS;
		else if (sh_q[6:0] <= `DACR_ADDR_CMOD && sh_q[6:0] != `DACR_ADDR_RSVD)
			rdata = regs_q[sh_q[3:0]];
		else
			rdata = 8'h00;
		rsh_d = (cnt_q == 5'd8) ? rdata : {rsh_q[6:0], 1'b0};
		oe_d = rd_q && (cnt_q >= 5'd8) && (cnt_q < 5'd16);
	end

	always_ff @(negedge sclk or posedge frm_rst)
	begin
		if (frm_rst)
		begin
			rsh_q <= 8'h00;
			oe_q <= 1'b0;
		end
		else
		begin
			rsh_q <= rsh_d;
			oe_q <= oe_d;
		end
	end

	assign spi_sdin_o = rsh_q[7];
	assign spi_sdin_oe = oe_q;
	assign cfg_tgl = tgl_q;
	assign cfg_img = {regs_q[5], regs_q[4], regs_q[3], regs_q[2], regs_q[1], regs_q[0]};

	property p_soft_reset;
		@(posedge sclk) disable iff (sys_rst)
		(commit && word[14:8] == `DACR_ADDR_SRST && word[7:0] == `DACR_SRST_CODE)
		|=> (regs_q[0] == `DACR_RST_PWR) && (regs_q[3] == `DACR_RST_SKEW);
	endproperty
	chk_soft_reset_defaults: assert property (p_soft_reset)
		else $error("soft reset did not restore defaults");

	chk_read_drive_phase: assert property (
		@(posedge sclk) disable iff (frm_rst)
		(cnt_q == 5'd9 && rd_q) |-> spi_sdin_oe)
		else $error("read data not driven after address byte");
endmodule

// ==== testbench/dacr_host.sv ====
// dacr_host: host side of the 3-wire serial port, one frame per xfer call
// assumes: sd_wire is the resolved data line; sclk stands still outside frames except during tick
`timescale 1ns/1ps
module dacr_host (
	output logic sclk,
	output logic spi_cs_n,
	output logic host_sd,
	output logic host_sd_oe,
	input wire logic sd_wire
);
	initial
	begin
		sclk = 1'b0;
		spi_cs_n = 1'b1;
		host_sd = 1'b0;
		host_sd_oe = 1'b0;
	end
	// rw bit, seven address bits, eight data bits, msb first
	task automatic xfer(input logic rw, input logic [6:0] a, input logic [7:0] wd,
		output logic [7:0] rd);
		logic [15:0] w;
		w = {rw, a, wd};
		rd = 8'h00;
		spi_cs_n = 1'b0;
		host_sd_oe = 1'b1;
		for (int i = 15; i >= 0; i--)
		begin
			if (host_sd_oe)
				host_sd = w[i];
			#7.5 sclk = 1'b1;
			if (rw && i < 8)
				rd[i] = sd_wire;
			#7.5 sclk = 1'b0;
			// let go of the line only after the last address bit was taken
			if (rw && i == 8)
				host_sd_oe = 1'b0;
		end
		#7.5 spi_cs_n = 1'b1; // chip select rises after every frame
		host_sd_oe = 1'b0;
		#600;
	endtask
	// clock edges with chip select high, used while reset is held
	task automatic tick();
		repeat (2)
		begin
			#7.5 sclk = 1'b1;
			#7.5 sclk = 1'b0;
		end
	endtask
endmodule

// ==== testbench/dacr_tb_top.sv ====
// dacr_tb_top: self-checking bench for the converter configuration core
// assumes: dacr_host model on the serial port; 10 MHz sample clock
`timescale 1ns/1ps
module dacr_tb_top
	import dacr_pkg::*;
;
	typedef struct packed {
		logic [6:0] addr;
		logic [7:0] data;
		logic pin;
		logic [15:0] exp;
	} dacr_row_s;
	localparam dacr_row_s rows [0:23] = '{
		'{7'h00, 8'h03, 1'b0, 16'h001E}, '{7'h00, 8'h03, 1'b1, 16'h0000},
		'{7'h00, 8'h01, 1'b0, 16'h0018}, '{7'h00, 8'h02, 1'b0, 16'h0006},
		'{7'h00, 8'h04, 1'b0, 16'h000A}, '{7'h00, 8'h05, 1'b0, 16'h001A},
		'{7'h00, 8'h06, 1'b0, 16'h000E}, '{7'h00, 8'h0C, 1'b0, 16'h000A},
		'{7'h00, 8'h0A, 1'b0, 16'h001F}, '{7'h00, 8'h90, 1'b1, 16'h001F},
		'{7'h00, 8'h30, 1'b1, 16'h001E}, '{7'h00, 8'h08, 1'b0, 16'h0000},
		'{7'h03, 8'h80, 1'b0, 16'h0080}, '{7'h03, 8'h49, 1'b0, 16'h0049},
		'{7'h03, 8'h1A, 1'b0, 16'h001A}, '{7'h03, 8'h2E, 1'b0, 16'h003E},
		'{7'h03, 8'h3F, 1'b0, 16'h002D}, '{7'h03, 8'h24, 1'b0, 16'h0000},
		'{7'h04, 8'h00, 1'b0, 16'h0000}, '{7'h04, 8'h0A, 1'b0, 16'h000B},
		'{7'h04, 8'h1C, 1'b0, 16'h0016}, '{7'h05, 8'h2B, 1'b0, 16'h0032},
		'{7'h05, 8'h07, 1'b0, 16'h0006}, '{7'h05, 8'h11, 1'b0, 16'h0019}};
	logic mclk, sys_rst, pin, sclk, spi_cs_n, host_sd, host_oe, sd_o, sd_oe, sd_w;
	logic idle_q = 1'b0;
	logic [7:0] chan_a_code, chan_b_code, bus_a, bus_b, v0, v1;
	logic chan_a_over, chan_b_over, averaging_active, bus_a_oe, bus_b_oe, c0;
	logic overrange_flag_out, overrange_oe, output_data_clock, out_clock_oe;
	logic aligner_skip, half_period_delay;
	dacr_chpwr_e first_channel_power, second_channel_power;
	dacr_step_t out_clock_skew_field, data_skew_field;
	dacr_term_e first_clock_termination, first_data_termination;
	dacr_term_e second_clock_termination, second_data_termination;
	int num_errors = 0;
	int check_count = 0;
	// released data line shows a changing pattern, not its last value
	assign sd_w = sd_oe ? sd_o : (host_oe ? host_sd : idle_q);
	dacr_top dacr_top_i (.mclk(mclk), .sys_rst(sys_rst), .sclk(sclk), .spi_cs_n(spi_cs_n),
		.spi_sdin_i(sd_w), .spi_sdin_o(sd_o), .spi_sdin_oe(sd_oe),
		.power_set_select_pin(pin), .chan_a_code(chan_a_code), .chan_b_code(chan_b_code),
		.chan_a_over(chan_a_over), .chan_b_over(chan_b_over),
		.first_channel_power(first_channel_power), .second_channel_power(second_channel_power),
		.averaging_active(averaging_active), .bus_a(bus_a), .bus_a_oe(bus_a_oe),
		.bus_b(bus_b), .bus_b_oe(bus_b_oe), .overrange_flag_out(overrange_flag_out),
		.overrange_oe(overrange_oe), .output_data_clock(output_data_clock),
		.out_clock_oe(out_clock_oe), .aligner_skip(aligner_skip),
		.half_period_delay(half_period_delay), .out_clock_skew_field(out_clock_skew_field),
		.data_skew_field(data_skew_field), .first_clock_termination(first_clock_termination),
		.first_data_termination(first_data_termination),
		.second_clock_termination(second_clock_termination),
		.second_data_termination(second_data_termination));
	dacr_host dacr_host_i (.sclk(sclk), .spi_cs_n(spi_cs_n), .host_sd(host_sd),
		.host_sd_oe(host_oe), .sd_wire(sd_w));
	initial
	begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	always @(posedge mclk)
		idle_q <= ~idle_q;
	function automatic logic [15:0] obs(input logic [6:0] a);
		case (a)
			7'h00: obs = {11'h000, first_channel_power, second_channel_power, averaging_active};
			7'h03: obs = {8'h00, aligner_skip, half_period_delay, out_clock_skew_field,
				data_skew_field};
			7'h04: obs = {10'h000, first_clock_termination, first_data_termination};
			default: obs = {10'h000, second_clock_termination, second_data_termination};
		endcase
	endfunction
	task automatic final_report();
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp)
		begin
			num_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
		#5;
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		logic [7:0] r;
		dacr_host_i.xfer(1'b0, a, d, r);
	endtask
	task automatic rd_chk(input logic [6:0] a, input logic [7:0] e);
		logic [7:0] r;
		dacr_host_i.xfer(1'b1, a, 8'h00, r);
		cmp({8'h00, r}, {8'h00, e});
	endtask
	// bus selected by sel; a released bus is compared on its enable only
	task automatic chk_bus(input logic sel, input logic [8:0] e);
		logic [8:0] g;
		g = sel ? {bus_b_oe, bus_b} : {bus_a_oe, bus_a};
		if (!e[8])
			g[7:0] = 8'h00;
		cmp({7'h00, g}, {7'h00, e});
	endtask
	// single bus alternates the two channel words
	task automatic mux_chk(input logic sel);
		v0 = sel ? bus_b : bus_a;
		cyc(1);
		v1 = sel ? bus_b : bus_a;
		cmp({v0, v1} == 16'h1E0F || {v0, v1} == 16'h0F1E ? 16'h0001 : {v0, v1}, 16'h0001);
	endtask
	task automatic do_reset();
		sys_rst = 1'b1;
		dacr_host_i.tick();
		cyc(2);
		sys_rst = 1'b0;
		cyc(2);
	endtask
	initial
	begin
		#2000000;
		num_errors++;
		final_report();
	end
	initial
	begin
		pin = 1'b0;
		chan_a_code = 8'h1E;
		chan_b_code = 8'h0F;
		chan_a_over = 1'b1;
		chan_b_over = 1'b0;
		do_reset();
		for (int a = 0; a < 12; a++)
			rd_chk(a[6:0], a == 0 ? 8'h03 : a == 3 ? 8'h80 : a == 10 ? 8'h14 : 8'h00);
		foreach (rows[i])
		begin
			wr(rows[i].addr, rows[i].data);
			cyc(1);
			pin = rows[i].pin;
			cyc(6);
			cmp(obs(rows[i].addr), rows[i].exp);
			rd_chk(rows[i].addr, rows[i].data);
		end
		pin = 1'b0;
		wr(7'h00, 8'h03);
		wr(7'h01, 8'h00);
		cyc(3);
		chk_bus(1'b0, 9'h11E);
		chk_bus(1'b1, 9'h10F);
		wr(7'h01, 8'h18);
		cyc(3);
		chk_bus(1'b0, 9'h178);
		chk_bus(1'b1, 9'h1F0);
		wr(7'h01, 8'h02);
		cyc(3);
		mux_chk(1'b0);
		chk_bus(1'b1, 9'h000);
		wr(7'h01, 8'h06);
		cyc(3);
		mux_chk(1'b1);
		chk_bus(1'b0, 9'h000);
		wr(7'h03, 8'h40);
		cyc(3);
		cmp({15'h0000, half_period_delay}, 16'h0000);
		wr(7'h01, 8'h00);
		cyc(3);
		cmp({15'h0000, half_period_delay}, 16'h0001);
		wr(7'h00, 8'h09);
		cyc(3);
		chk_bus(1'b0, 9'h116);
		wr(7'h01, 8'h04);
		cyc(3);
		chk_bus(1'b1, 9'h116);
		chk_bus(1'b0, 9'h000);
		wr(7'h01, 8'h00);
		wr(7'h00, 8'h03);
		wr(7'h02, 8'h03);
		cyc(3);
		cmp({14'h0000, overrange_oe, out_clock_oe}, 16'h0000);
		wr(7'h02, 8'h00);
		cyc(3);
		cmp({14'h0000, overrange_oe, out_clock_oe}, 16'h0003);
		cmp({15'h0000, overrange_flag_out}, 16'h0001);
		chan_a_over = 1'b0;
		cyc(2);
		cmp({15'h0000, overrange_flag_out}, 16'h0000);
		c0 = output_data_clock;
		cyc(1);
		cmp({15'h0000, c0 ^ output_data_clock}, 16'h0001);
		pin = 1'b1;
		for (int i = 0; i < 4; i++)
		begin
			wr(7'h02, {4'h0, i[1:0], 2'b00});
			cyc(3);
			chk_bus(1'b0, i == 1 ? 9'h100 : i == 3 ? 9'h1FF : 9'h000);
		end
		wr(7'h00, 8'h05);
		wr(7'h07, 8'hFF);
		wr(7'h0A, 8'h12);
		rd_chk(7'h00, 8'h05);
		rd_chk(7'h07, 8'h00);
		wr(7'h0A, 8'h5A);
		cyc(3);
		rd_chk(7'h00, 8'h03);
		rd_chk(7'h02, 8'h00);
		cmp(obs(7'h03), 16'h0080);
		wr(7'h01, 8'h18);
		do_reset();
		rd_chk(7'h01, 8'h00);
		final_report();
	end
endmodule
